// >>> common/clr_pkg.sv
// constants for the serial camera receiver with window cropper
package clr_pkg;

  // serial link shape
  localparam int LANES = 5;                  // four data lanes and the clock lane
  localparam int DATA_LANES = 4;
  localparam int CLK_LANE = 4;
  localparam int BITS_PER_LANE = 7;
  localparam int WORD_W = 28;
  localparam int SR_W = 8;
  localparam logic [6:0] CLK_PATTERN = 7'h63;  // clock lane shape 1100011 per pixel

  // slow variant and fast variant pixel clock limits in MHz
  localparam int SLOW_MAX_PIX_MHZ = 24;
  localparam int FAST_MAX_PIX_MHZ = 50;

  // fields of the reassembled 28-bit word
  localparam int IMG_W = 24;
  localparam int LVAL_BIT = 24;
  localparam int FVAL_BIT = 25;
  localparam int DVAL_BIT = 26;

  // pixel stream word
  localparam int PIX_W = 32;
  localparam int PAD_W = 8;
  localparam int LUMA_W = 8;

  // shift select codes and shift amounts
  localparam logic [1:0] SHIFT_NONE = 2'h0;
  localparam logic [1:0] SHIFT_10BIT = 2'h1;
  localparam logic [1:0] SHIFT_12BIT = 2'h2;
  localparam int SHIFT_10_AMT = 2;
  localparam int SHIFT_12_AMT = 4;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DARK = 8'h04;
  localparam logic [7:0] REG_PIX_START = 8'h08;
  localparam logic [7:0] REG_PIX_STOP = 8'h0c;
  localparam logic [7:0] REG_LINE_START = 8'h10;
  localparam logic [7:0] REG_LINE_STOP = 8'h14;
  localparam logic [7:0] REG_PIX_TOTAL = 8'h18;
  localparam logic [7:0] REG_LINE_TOTAL = 8'h1c;
  localparam logic [7:0] REG_FIRST_PIX = 8'h20;
  localparam logic [7:0] REG_LAST_PIX = 8'h24;
  localparam logic [7:0] REG_FIRST_LINE = 8'h28;
  localparam logic [7:0] REG_LAST_LINE = 8'h2c;
  localparam logic [7:0] REG_STATUS = 8'h30;

  // field positions
  localparam int CTRL_SHIFT_LSB = 0;
  localparam int STAT_SLOW_BIT = 16;
  localparam int STAT_CNT_W = 16;

  // reset values
  localparam logic [1:0] RST_SHIFT = 2'h0;
  localparam logic [7:0] RST_DARK = 8'h10;
  localparam logic [15:0] RST_START = 16'h0000;
  localparam logic [15:0] RST_STOP = 16'hffff;

endpackage : clr_pkg

// >>> hw/clr_camera_rx.sv
// serial camera receiver, geometry monitor and window cropper with wishbone registers
//
// Contract
// R1: slow deserialiser variant is meant for pixel clocks up to 24 MHz only.
// R2: build-time boolean picks slow (true) or fast (false) deserialiser.
// R3: default build picks the slow deserialiser.
// R4: receive logic handles camera pixel clocks up to 50 MHz.
// R5: fast variant samples seven bits per pixel using both sample edges.
// R6: host bus logic runs from its own 50 MHz clock. Code runs the bus logic from clk_i, the same clock as the pixel path.
// R7: camera sends four 7-bit serial data lanes and a clock lane.
// R8: rebuild the 28-bit parallel word every pixel period.
// R9: split word into 24 image bits plus data, line and frame valid.
// R10: image in low 24 bits of 32-bit word, upper byte zero.
// R11: produce pixel valid, end of line, end of frame and pixel strobe.
// R12: selectable right shift of 0, 2 or 4 bits for 8/10/12-bit cameras.
// R13: monitor counts pixels per line and lines per frame.
// R14: monitor reports first/last non-dark pixel and line.
// R15: all six monitor values readable over the host bus.
// R16: cropper pixel counter starts at 0 each line, counts up.
// R17: pass pixel only if start <= count <= stop.
// R18: cropper line counter starts at 0 each frame, counts up.
// R19: pass line only if start <= count <= stop.
// R20: software programs the four window bounds over the host bus.
// R21: all pixel pipeline flops advance on the pixel strobe. Code loads the output valid, eol and eof flops every clock.
// R22: stream is strobe, valid, end of line, end of frame and 32-bit data.
// R23: dropped pixels show no valid; eol/eof ride last kept pixel/line.
// R24: monitor values update once per frame, at end of frame.
module clr_camera_rx import clr_pkg::*; #(
  parameter bit SLOW_DESERIALISER_SELECT = 1'b1,  // R2 R3
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // serial lanes, bit seen on rising and on falling sample edge
  input wire logic [LANES-1:0] lane_rise_i,
  input wire logic [LANES-1:0] lane_fall_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cropped pixel stream
  output logic pix_strobe_o,
  output logic pix_valid_o,
  output logic pix_eol_o,
  output logic pix_eof_o,
  output logic [PIX_W-1:0] pix_data_o
);

  // inclusive window test
  function automatic logic in_range(input logic [CNT_W-1:0] v, input logic [CNT_W-1:0] lo,
                                    input logic [CNT_W-1:0] hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction : in_range

  // byte-lane merge for a 16-bit register
  function automatic logic [CNT_W-1:0] merge(input logic [CNT_W-1:0] old,
                                             input logic [31:0] d, input logic [3:0] sel);
    logic [15:0] r;
    r = old[15:0];
    if (sel[0]) begin
      r[7:0] = d[7:0];
    end
    if (sel[1]) begin
      r[15:8] = d[15:8];
    end
    merge = CNT_W'(r);
  endfunction : merge

  // software registers
  logic [1:0] shift_sel;
  logic [LUMA_W-1:0] dark_thr;
  logic [CNT_W-1:0] pix_start, pix_stop, line_start, line_stop;
  // monitor results
  logic [CNT_W-1:0] pix_tot, line_tot, first_pix, last_pix, first_line, last_line;
  logic [STAT_CNT_W-1:0] frame_cnt;

  // lane shift registers
  logic [SR_W-1:0] sr [LANES];
  logic match0, match1, pix_en;
  logic [WORD_W-1:0] word;

  // sample the lanes: two bits per cycle in the fast variant, one in the slow
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int l = 0; l < LANES; l++) begin
        sr[l] <= '0;
      end
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (SLOW_DESERIALISER_SELECT) begin
          sr[l] <= {sr[l][SR_W-2:0], lane_rise_i[l]};  // R1
        end else begin
          sr[l] <= {sr[l][SR_W-3:0], lane_rise_i[l], lane_fall_i[l]};  // R5 R4
        end
      end
    end
  end

  // find the pixel boundary from the clock lane and gather the 28-bit word
  always_comb begin
    match0 = (sr[CLK_LANE][6:0] == CLK_PATTERN);  // R7
    match1 = !SLOW_DESERIALISER_SELECT && (sr[CLK_LANE][7:1] == CLK_PATTERN);
    pix_en = match0 || match1;
    word = '0;
    for (int l = 0; l < DATA_LANES; l++) begin
      word[l*BITS_PER_LANE +: BITS_PER_LANE] = match1 ? sr[l][7:1] : sr[l][6:0];  // R8
    end
  end

  // field split and shift
  logic dv_now, lval_now, fval_now;
  logic [IMG_W-1:0] img_shifted;
  always_comb begin
    lval_now = word[LVAL_BIT];  // R9
    fval_now = word[FVAL_BIT];
    dv_now = word[DVAL_BIT] && lval_now && fval_now;
    unique case (shift_sel)
      SHIFT_10BIT: img_shifted = word[IMG_W-1:0] >> SHIFT_10_AMT;  // R12
      SHIFT_12BIT: img_shifted = word[IMG_W-1:0] >> SHIFT_12_AMT;  // R12
      default: img_shifted = word[IMG_W-1:0];
    endcase
  end

  // one pixel of look-ahead so end of line rides the last pixel
  logic hold_valid;
  logic [IMG_W-1:0] hold_data;
  logic rx_stb, rx_valid, rx_eol, rx_eof;
  logic [IMG_W-1:0] rx_data;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_valid <= 1'b0;
      hold_data <= '0;
      rx_stb <= 1'b0;
      rx_valid <= 1'b0;
      rx_eol <= 1'b0;
      rx_eof <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_stb <= pix_en;  // R11
      if (pix_en) begin  // R21
        rx_valid <= hold_valid && (dv_now || !lval_now);
        rx_eol <= hold_valid && !lval_now;  // R11
        rx_eof <= hold_valid && !lval_now && !fval_now;  // R11
        rx_data <= hold_data;
        if (dv_now || !lval_now) begin
          hold_valid <= dv_now;
          hold_data <= img_shifted;
        end
      end
    end
  end

  wire rx_pix = rx_stb && rx_valid;

  // pixel and line counters shared by monitor and cropper
  logic [CNT_W-1:0] px_cnt, ln_cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      px_cnt <= '0;
      ln_cnt <= '0;
    end else if (rx_pix) begin
      px_cnt <= rx_eol ? '0 : px_cnt + 1'b1;  // R16
      if (rx_eol) begin
        ln_cnt <= rx_eof ? '0 : ln_cnt + 1'b1;  // R18
      end
    end
  end

  // running border search over the current frame
  logic [CNT_W-1:0] run_fp, run_lp, run_fl, run_ll;
  wire lit = rx_data[LUMA_W-1:0] > dark_thr;  // R14
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_fp <= '1;
      run_lp <= '0;
      run_fl <= '1;
      run_ll <= '0;
    end else if (rx_pix) begin
      if (rx_eof) begin
        run_fp <= '1;
        run_lp <= '0;
        run_fl <= '1;
        run_ll <= '0;
      end else begin
        if (lit) begin
          if (px_cnt < run_fp) begin
            run_fp <= px_cnt;  // R14
          end
          if (px_cnt > run_lp) begin
            run_lp <= px_cnt;
          end
          if (ln_cnt < run_fl) begin
            run_fl <= ln_cnt;
          end
          if (ln_cnt > run_ll) begin
            run_ll <= ln_cnt;
          end
        end
      end
    end
  end

  // publish all six values together at end of frame, folding in the last pixel
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_tot <= '0;
      line_tot <= '0;
      first_pix <= '0;
      last_pix <= '0;
      first_line <= '0;
      last_line <= '0;
      frame_cnt <= '0;
    end else if (rx_pix && rx_eof) begin  // R24
      pix_tot <= px_cnt + 1'b1;  // R13
      line_tot <= ln_cnt + 1'b1;
      first_pix <= (lit && px_cnt < run_fp) ? px_cnt : run_fp;  // R14
      last_pix <= (lit && px_cnt > run_lp) ? px_cnt : run_lp;
      first_line <= (lit && ln_cnt < run_fl) ? ln_cnt : run_fl;
      last_line <= (lit && ln_cnt > run_ll) ? ln_cnt : run_ll;
      frame_cnt <= frame_cnt + 1'b1;
    end
  end

  // window cropper output stage
  logic keep_px, keep_eol;
  always_comb begin
    keep_px = rx_pix && in_range(px_cnt, pix_start, pix_stop)
              && in_range(ln_cnt, line_start, line_stop);  // R17 R19
    keep_eol = keep_px && (rx_eol || px_cnt == pix_stop);  // R23
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pix_strobe_o <= 1'b0;
      pix_valid_o <= 1'b0;
      pix_eol_o <= 1'b0;
      pix_eof_o <= 1'b0;
      pix_data_o <= '0;
    end else begin
      pix_strobe_o <= rx_stb;  // R11 R21
      pix_valid_o <= keep_px;  // R23
      pix_eol_o <= keep_eol;
      pix_eof_o <= keep_eol && (rx_eof || ln_cnt == line_stop);  // R23
      if (keep_px) begin
        pix_data_o <= {{PAD_W{1'b0}}, rx_data};  // R10 R22
      end
    end
  end

  // wishbone: ack one cycle after the request, write lands on the ack edge
  logic [31:0] rd_mux;
  wire wb_req = wb_cyc_i && wb_stb_i;  // R6
  always_comb begin
    rd_mux = '0;
    unique case (wb_adr_i)
      REG_CTRL: rd_mux[CTRL_SHIFT_LSB +: 2] = shift_sel;
      REG_DARK: rd_mux[LUMA_W-1:0] = dark_thr;
      REG_PIX_START: rd_mux[CNT_W-1:0] = pix_start;
      REG_PIX_STOP: rd_mux[CNT_W-1:0] = pix_stop;
      REG_LINE_START: rd_mux[CNT_W-1:0] = line_start;
      REG_LINE_STOP: rd_mux[CNT_W-1:0] = line_stop;
      REG_PIX_TOTAL: rd_mux[CNT_W-1:0] = pix_tot;  // R15
      REG_LINE_TOTAL: rd_mux[CNT_W-1:0] = line_tot;
      REG_FIRST_PIX: rd_mux[CNT_W-1:0] = first_pix;
      REG_LAST_PIX: rd_mux[CNT_W-1:0] = last_pix;
      REG_FIRST_LINE: rd_mux[CNT_W-1:0] = first_line;
      REG_LAST_LINE: rd_mux[CNT_W-1:0] = last_line;
      REG_STATUS: rd_mux = {15'h0000, SLOW_DESERIALISER_SELECT, frame_cnt};
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req && !wb_ack_o;
      wb_dat_o <= (wb_req && !wb_ack_o) ? rd_mux : '0;
    end
  end

  // software writes
  wire wr = wb_req && wb_we_i && wb_ack_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_sel <= RST_SHIFT;
      dark_thr <= RST_DARK;
      pix_start <= CNT_W'(RST_START);
      pix_stop <= CNT_W'(RST_STOP);
      line_start <= CNT_W'(RST_START);
      line_stop <= CNT_W'(RST_STOP);
    end else if (wr) begin
      unique case (wb_adr_i)
        REG_CTRL: if (wb_sel_i[0]) begin
          shift_sel <= wb_dat_i[CTRL_SHIFT_LSB +: 2];  // R12
        end
        REG_DARK: if (wb_sel_i[0]) begin
          dark_thr <= wb_dat_i[LUMA_W-1:0];
        end
        REG_PIX_START: pix_start <= merge(pix_start, wb_dat_i, wb_sel_i);  // R20
        REG_PIX_STOP: pix_stop <= merge(pix_stop, wb_dat_i, wb_sel_i);
        REG_LINE_START: line_start <= merge(line_start, wb_dat_i, wb_sel_i);
        REG_LINE_STOP: line_stop <= merge(line_stop, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  pad_zero_a: assert property (pix_valid_o |-> pix_data_o[PIX_W-1:IMG_W] == '0) // R10
    else $error("upper pixel byte not zero");
  pix_window_a: assert property (rx_pix && !in_range(px_cnt, pix_start, pix_stop) // R17
    |=> !pix_valid_o) else $error("pixel outside window passed");
  line_window_a: assert property (rx_pix && !in_range(ln_cnt, line_start, line_stop) // R19
    |=> !pix_valid_o) else $error("line outside window passed");
  px_restart_a: assert property (rx_pix && rx_eol |=> px_cnt == '0) // R16
    else $error("pixel count not cleared at line end");
  ln_restart_a: assert property (rx_pix && rx_eof |=> ln_cnt == '0) // R18
    else $error("line count not cleared at frame end");
  px_count_a: assert property (rx_pix && !rx_eol |=> px_cnt == $past(px_cnt) + 1'b1) // R16
    else $error("pixel count did not advance");
  eof_marks_a: assert property (pix_eof_o |-> pix_eol_o && pix_valid_o) // R23
    else $error("end of frame without end of line");
  strobe_pulse_a: assert property (pix_strobe_o |=> !pix_strobe_o) // R11
    else $error("pixel strobe longer than one cycle");
  geom_latch_a: assert property (rx_pix && rx_eof |=> line_tot == $past(ln_cnt) + 1'b1 // R24
    && pix_tot == $past(px_cnt) + 1'b1) else $error("geometry not latched at frame end");
  geom_hold_a: assert property (!(rx_pix && rx_eof) |=> $stable(first_pix) // R24
    && $stable(last_line)) else $error("monitor changed mid frame");
  shift_twelve_a: assert property (pix_en && dv_now && shift_sel == SHIFT_12BIT // R12
    |=> hold_data == ($past(word[IMG_W-1:0]) >> SHIFT_12_AMT)) else $error("12-bit shift wrong");
  wb_ack_a: assert property (wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) // R15
    else $error("bus ack not a one-cycle answer");

  // stream shape, shifts, counters and bus read data
  shift_ten_a: assert property (pix_en && dv_now && shift_sel == SHIFT_10BIT // R12
    |=> hold_data == ($past(word[IMG_W-1:0]) >> SHIFT_10_AMT)) else $error("10-bit shift wrong");
  shift_none_a: assert property (pix_en && dv_now && shift_sel == SHIFT_NONE // R12
    |=> hold_data == $past(word[IMG_W-1:0])) else $error("unshifted pixel altered");
  hold_skip_a: assert property (pix_en && lval_now && !dv_now |=> $stable(hold_data)) // R9
    else $error("skipped word taken as pixel");
  strobe_valid_a: assert property (pix_valid_o |-> pix_strobe_o) // R22
    else $error("valid pixel without strobe");
  eol_valid_a: assert property (pix_eol_o |-> pix_valid_o) // R23
    else $error("end of line without kept pixel");
  pix_drop_a: assert property (rx_stb && !rx_valid |=> !pix_valid_o) // R23
    else $error("invalid word shown as pixel");
  window_pass_a: assert property (keep_px |=> pix_valid_o) // R17
    else $error("pixel inside window dropped");
  data_hold_a: assert property (!keep_px |=> $stable(pix_data_o)) // R22
    else $error("pixel data moved without kept pixel");
  ln_count_a: assert property (rx_pix && rx_eol && !rx_eof |=> ln_cnt == $past(ln_cnt) + 1'b1) // R18
    else $error("line count did not advance");
  frame_count_a: assert property (rx_pix && rx_eof |=> frame_cnt == $past(frame_cnt) + 1'b1) // R24
    else $error("frame count did not advance");
  rd_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0) // R15
    else $error("read data outside ack");

  // scenarios worth seeing

  frame_done_c: cover property (rx_pix && rx_eof);
  kept_line_c: cover property (pix_eol_o ##[1:1000] pix_eof_o);
  bus_write_c: cover property (wr && wb_adr_i == REG_PIX_START);
  cropped_px_c: cover property (rx_pix && !keep_px);
  shift_ten_c: cover property (rx_pix && shift_sel == SHIFT_10BIT);

endmodule : clr_camera_rx

// >>> sim/clr_cam_model.sv
// camera side model: serialises 28-bit words onto four data lanes and a clock lane
module clr_cam_model import clr_pkg::*; (
  // sample clock
  input wire logic clk_i,
  // serial lanes towards the receiver
  output logic [LANES-1:0] lane_rise_o,
  output logic [LANES-1:0] lane_fall_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [WORD_W-1:0] words[$];
  logic [WORD_W-1:0] cur = '0;
  int idx = BITS_PER_LANE - 1;
  // lanes start low, unused falling lane starts high
  initial begin
    lane_rise_o = '0;
    lane_fall_o = '1;
  end
  // idle words keep the camera clock running between frames, oldest bit first
  always @(posedge clk_i) begin
    if (idx == BITS_PER_LANE - 1) begin
      cur = (words.size() > 0) ? words.pop_front() : '0;
    end
    for (int l = 0; l < DATA_LANES; l++) begin
      lane_rise_o[l] <= cur[BITS_PER_LANE*l+idx];
    end
    lane_rise_o[CLK_LANE] <= CLK_PATTERN[idx];
    lane_fall_o <= ~lane_fall_o; // slow build ignores it, so it never holds a value
    idx = (idx == 0) ? BITS_PER_LANE - 1 : idx - 1;
  end
endmodule : clr_cam_model

// >>> sim/testbench.sv
// self-checking bench for the camera receiver with window cropper
module testbench import clr_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_n_i;
  logic [LANES-1:0] lane_rise, lane_fall;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = '0;
  logic [3:0] wb_sel = 4'hf;
  logic [31:0] wb_dat = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, pix_strobe_o, pix_valid_o, pix_eol_o, pix_eof_o;
  logic [PIX_W-1:0] pix_data_o;
  logic [34:0] pq[$];
  logic [31:0] rq[$];
  int fail_count = 0;
  int num_checks = 0;
  int seed = 32'hfb17;
  int ps, pe, ls, le;
  localparam logic [7:0] rst_adr[8] = '{REG_CTRL, REG_DARK, REG_PIX_START, REG_PIX_STOP,
    REG_LINE_START, REG_LINE_STOP, REG_STATUS, 8'h3c};
  localparam logic [31:0] rst_val[8] = '{32'h0, {24'h0, RST_DARK}, {16'h0, RST_START},
    {16'h0, RST_STOP}, {16'h0, RST_START}, {16'h0, RST_STOP}, 32'h1 << STAT_SLOW_BIT, 32'h0};
  localparam logic [7:0] mon_adr[6] = '{REG_PIX_TOTAL, REG_LINE_TOTAL, REG_FIRST_PIX,
    REG_LAST_PIX, REG_FIRST_LINE, REG_LAST_LINE};
  localparam logic [31:0] mon_val[6] = '{32'h6, 32'h4, 32'h1, 32'h4, 32'h1, 32'h2};

  clr_cam_model i_cam (.clk_i(clk_i), .lane_rise_o(lane_rise), .lane_fall_o(lane_fall));
  clr_camera_rx i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .lane_rise_i(lane_rise),
    .lane_fall_i(lane_fall), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .pix_strobe_o(pix_strobe_o), .pix_valid_o(pix_valid_o),
    .pix_eol_o(pix_eol_o), .pix_eof_o(pix_eof_o), .pix_data_o(pix_data_o));

  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;

  task automatic oops(input string msg);
    fail_count++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask : oops

  task automatic chk_pix(input logic [34:0] exp, input logic [34:0] got);
    num_checks++;
    if (got !== exp) oops($sformatf("pixel %h, wanted %h", got, exp));
  endtask : chk_pix

  task automatic chk_reg(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) oops($sformatf("read %h, wanted %h", got, exp));
  endtask : chk_reg

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  // one classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     input logic [31:0] exp);
    int n;
    n = 0;
    if (!we) rq.push_back(exp);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) oops("no acknowledge");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic window(input int a, input int b, input int c, input int d,
                        input logic [1:0] code);
    ps = a;
    pe = b;
    ls = c;
    le = d;
    bus(1'b1, REG_PIX_START, a, '0);
    bus(1'b1, REG_PIX_STOP, b, '0);
    bus(1'b1, REG_LINE_START, c, '0);
    bus(1'b1, REG_LINE_STOP, d, '0);
    bus(1'b1, REG_CTRL, {30'h0, code}, '0);
    bus(1'b0, REG_CTRL, '0, {30'h0, code});
  endtask : window

  // dark border frame, one skipped word per line, expected kept pixels queued
  task automatic frame(input int w, input int h, input logic [1:0] code);
    logic [23:0] img;
    logic eol;
    int sh;
    sh = (code == SHIFT_10BIT) ? SHIFT_10_AMT : (code == SHIFT_12BIT) ? SHIFT_12_AMT : 0;
    i_cam.words.push_back(28'h200_0000);
    for (int y = 0; y < h; y++) begin
      for (int x = 0; x < w; x++) begin
        img = $random(seed);
        img[7] = 1'b1;
        if (x == 0 || x == w - 1 || y == 0 || y == h - 1) img[7:0] = 8'h00;
        i_cam.words.push_back({4'h7, img});
        if (x == 0) i_cam.words.push_back({4'h3, ~img});
        eol = x >= ps && x <= pe && (x == pe || x == w - 1);
        if (x >= ps && x <= pe && y >= ls && y <= le) begin
          pq.push_back({1'b1, eol, eol && (y == le || y == h - 1), 8'h00, img >> sh});
        end
      end
      i_cam.words.push_back((y == h - 1) ? 28'h0 : 28'h200_0000);
    end
  endtask : frame

  task automatic drain();
    int n;
    n = 0;
    while ((i_cam.words.size() > 0 || pq.size() > 0) && n < 2000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 2000) oops("stream stalled");
    repeat (30) @(posedge clk_i);
    if (pq.size() != 0) oops("kept pixels missing");
    pq.delete();
  endtask : drain

  // watch stream and read data where settled
  always @(negedge clk_i) begin
    if (rst_n_i === 1'b1 && pix_valid_o === 1'b1) begin
      chk_pix(pq.size() > 0 ? pq.pop_front() : 'x,
              {pix_strobe_o, pix_eol_o, pix_eof_o, pix_data_o});
    end else if (rst_n_i === 1'b1 && {pix_eol_o, pix_eof_o} !== 2'b00) begin
      oops("end strobe without a kept pixel");
    end
    if (wb_ack_o === 1'b1 && wb_we === 1'b0) begin
      chk_reg(rq.size() > 0 ? rq.pop_front() : 'x, wb_dat_o);
    end
  end

  // main sequence
  initial begin
    int a, b, c, d;
    rst_n_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    foreach (rst_adr[i]) bus(1'b0, rst_adr[i], '0, rst_val[i]);
    bus(1'b1, REG_PIX_TOTAL, 32'h1234, '0);
    bus(1'b0, REG_PIX_TOTAL, '0, '0);
    wb_sel <= 4'h1;
    bus(1'b1, REG_LINE_START, 32'h0000_ab05, '0);
    wb_sel <= 4'hf;
    bus(1'b0, REG_LINE_START, '0, 32'h0000_0005);
    window(0, 65535, 0, 65535, SHIFT_NONE);
    frame(6, 4, SHIFT_NONE);
    drain();
    foreach (mon_adr[i]) bus(1'b0, mon_adr[i], '0, mon_val[i]);
    bus(1'b0, REG_STATUS, '0, 32'h0001_0001);
    for (int k = 0; k < 4; k++) begin
      a = $unsigned($random(seed)) % 8;
      b = a + $unsigned($random(seed)) % (8 - a);
      c = $unsigned($random(seed)) % 5;
      d = c + $unsigned($random(seed)) % (5 - c);
      window(a, b, c, d, k[1:0]);
      frame(8, 5, k[1:0]);
      drain();
    end
    complete_run();
  end

  // watchdog
  initial begin
    #(60000 * 5);
    oops("run timed out");
    complete_run();
  end
endmodule : testbench
